//--- core/bad_decode_remap.v
// Address decode and remap for a link-to-parallel-bus bridge.
// Assumes requests are single-cycle strobes with address and type stable;
// configuration registers arrive as plain ports, one clock, sync reset.
//
// Contract
// RL1 - Display enable claims down, blocks up display
// RL2 - Frame buffer window is 0xA0000 to 0xBFFFF
// RL3 - Ten-bit decode matches display I/O aliases
// RL4 - Full decode needs bits 15:0 exactly
// RL5 - Full-decode bit selects mode, needs display enable
// RL6 - Palette snoop bit reads zero always
// RL7 - Filter blocks downstream upper-768 I/O aliases
// RL8 - Filter clear forwards whole I/O window
// RL9 - Filter set forwards upstream upper-768 aliases
// RL10 - Filter affects only I/O decode
// RL11 - Claim on primary windows, shift address
// RL12 - Non-prefetchable address minus base offset
// RL13 - Prefetchable address minus base offset
// RL14 - Secondary shifted windows not claimed upstream
// RL15 - Upstream window address plus window offset
// RL16 - Upstream primary limit is limit plus offset
// RL17 - Outside upstream window, address unchanged
// RL18 - Software keeps upstream window clear of others
// RL19 - Software programs remap bases before enable
// RL20 - Nonzero I/O remap count activates remap
// RL21 - Opaque range never claimed either side
// RL22 - I/O window 4-KB granules, base not above limit
// RL23 - Memory windows 1-MB granules, disable if inverted
// RL24 - Remap arithmetic full 64 bits, wraps
// RL25 - I/O remap zeroes the top count bits
`timescale 1ns/1ps
`default_nettype none
`include "bad_defs.vh"

module bad_decode_remap
#(
   parameter IO_AW  = 32,
   parameter RMW    = 5
)
(
   input  wire              clk_i,
   input  wire              srst_i,
   // Request
   input  wire              req_valid_i,
   input  wire              req_upstream_i,
   input  wire              req_is_io_i,
   input  wire [63:0]       req_addr_i,
   // Configuration
   input  wire              mem_space_en_i,
   input  wire              bus_master_en_i,
   input  wire              io_space_en_i,
   input  wire              display_enable_i,
   input  wire              display_full_io_decode_i,
   input  wire              palette_snoop_wr_i,
   input  wire              isa_filter_i,
   input  wire              remap_enable_i,
   input  wire              opaque_memory_enable_i,
   input  wire [63:0]       opaque_base_i,
   input  wire [63:0]       opaque_limit_i,
   input  wire [31:0]       io_base_i,
   input  wire [31:0]       io_limit_i,
   input  wire [RMW-1:0]    io_remap_count_i,
   input  wire [63:0]       primary_np_base_i,
   input  wire [63:0]       primary_np_limit_i,
   input  wire [63:0]       secondary_np_remap_base_i,
   input  wire [63:0]       primary_pf_base_i,
   input  wire [63:0]       primary_pf_limit_i,
   input  wire [63:0]       secondary_pf_remap_base_i,
   input  wire [63:0]       upstream_primary_base_i,
   input  wire [63:0]       upstream_secondary_base_i,
   input  wire [63:0]       upstream_secondary_limit_i,
   // Answer
   output reg               resp_valid_o,
   output reg               claim_o,
   output reg               fwd_down_o,
   output reg               fwd_up_o,
   output reg  [63:0]       out_addr_o,
   output reg               palette_snoop_o,
   output reg  [63:0]       upstream_primary_limit_o
);

   // ************************************************************
   // Base offsets, modulo 2^64
   // ************************************************************
   wire [63:0] np_base_offset;
   wire [63:0] pf_base_offset;
   wire [63:0] upstream_window_offset;
   wire [63:0] secondary_np_limit;
   wire [63:0] secondary_pf_limit;
   wire [63:0] nxt_upstream_primary_limit;

   assign np_base_offset         = primary_np_base_i - secondary_np_remap_base_i; // see RL12 RL24
   assign pf_base_offset         = primary_pf_base_i - secondary_pf_remap_base_i; // see RL13 RL24
   assign upstream_window_offset = upstream_primary_base_i - upstream_secondary_base_i; // see RL15
   assign secondary_np_limit     = primary_np_limit_i - np_base_offset; // see RL14
   assign secondary_pf_limit     = primary_pf_limit_i - pf_base_offset; // see RL14
   assign nxt_upstream_primary_limit = upstream_secondary_limit_i + upstream_window_offset; // see RL16

   // ************************************************************
   // Secondary image of a window, the primary one when not remapping
   // ************************************************************
   function [63:0] sec_image;
      input        remap;
      input [63:0] remapped;
      input [63:0] plain;
      begin
         sec_image = remap ? remapped : plain;
      end
   endfunction

   // ************************************************************
   // Window hits
   // ************************************************************
   wire np_pri_hit;
   wire pf_pri_hit;
   wire np_sec_hit;
   wire pf_sec_hit;
   wire upw_hit;
   wire disp_io_hit;
   wire io_win_hit;
   wire isa_alias;
   wire disp_mem_hit;
   wire opaque_hit;

   bad_mem_window #(.GRAN_LSB(`BAD_MEM_GRAN_LSB)) u_np_pri
   (
      .addr_i  (req_addr_i),
      .base_i  (primary_np_base_i),
      .limit_i (primary_np_limit_i),
      .hit_o   (np_pri_hit)
   );

   bad_mem_window #(.GRAN_LSB(`BAD_MEM_GRAN_LSB)) u_pf_pri
   (
      .addr_i  (req_addr_i),
      .base_i  (primary_pf_base_i),
      .limit_i (primary_pf_limit_i),
      .hit_o   (pf_pri_hit)
   );

   // Secondary images of the windows, shifted when remapping
   bad_mem_window #(.GRAN_LSB(`BAD_MEM_GRAN_LSB)) u_np_sec
   (
      .addr_i  (req_addr_i),
      .base_i  (sec_image(remap_enable_i, secondary_np_remap_base_i, primary_np_base_i)),
      .limit_i (sec_image(remap_enable_i, secondary_np_limit, primary_np_limit_i)),
      .hit_o   (np_sec_hit)
   );

   bad_mem_window #(.GRAN_LSB(`BAD_MEM_GRAN_LSB)) u_pf_sec
   (
      .addr_i  (req_addr_i),
      .base_i  (sec_image(remap_enable_i, secondary_pf_remap_base_i, primary_pf_base_i)),
      .limit_i (sec_image(remap_enable_i, secondary_pf_limit, primary_pf_limit_i)),
      .hit_o   (pf_sec_hit)
   );

   // Translation window is byte-exact
   bad_mem_window #(.GRAN_LSB(0)) u_upw
   (
      .addr_i  (req_addr_i),
      .base_i  (upstream_secondary_base_i),
      .limit_i (upstream_secondary_limit_i),
      .hit_o   (upw_hit)
   );

   bad_mem_window #(.GRAN_LSB(0)) u_opq
   (
      .addr_i  (req_addr_i),
      .base_i  (opaque_base_i),
      .limit_i (opaque_limit_i),
      .hit_o   (opaque_hit)
   );

   bad_io_decode u_io
   (
      .io_addr_i                (req_addr_i[31:0]),
      .io_base_i                (io_base_i),
      .io_limit_i               (io_limit_i),
      .isa_filter_i             (isa_filter_i),
      .display_full_io_decode_i (display_full_io_decode_i),
      .disp_hit_o               (disp_io_hit),
      .win_hit_o                (io_win_hit),
      .isa_alias_o              (isa_alias)
   );

   assign disp_mem_hit = (req_addr_i >= `BAD_DISP_MEM_LO) &&
                         (req_addr_i <= `BAD_DISP_MEM_HI); // see RL2

   // ************************************************************
   // Forwarding decision
   // ************************************************************
   wire        io_up_addr;
   wire        disp_any;
   wire        opq_block;
   reg         nxt_fwd_down;
   reg         nxt_fwd_up;
   reg  [63:0] nxt_out_addr;
   wire [IO_AW-1:0] io_mask;
   genvar      g;

   assign io_up_addr = req_is_io_i && req_addr_i[63:IO_AW] != {(64-IO_AW){1'b0}};
   assign disp_any   = display_enable_i &&
                       (req_is_io_i ? disp_io_hit : disp_mem_hit); // see RL1 RL5
   assign opq_block  = opaque_memory_enable_i && !req_is_io_i && opaque_hit; // see RL21

   // ************************************************************
   // I/O upper-bit remap mask
   // ************************************************************
   generate
      for (g = 0; g < IO_AW; g = g + 1)
      begin : g_io_mask
         // Drop the top count bits of the I/O address
         assign io_mask[g] = (g < IO_AW - io_remap_count_i); // see RL20 RL25
      end
   endgenerate

   always @*
   begin
      nxt_fwd_down = 1'b0;
      nxt_fwd_up   = 1'b0;
      nxt_out_addr = req_addr_i;
      if (opq_block)
      begin
         nxt_fwd_down = 1'b0; // see RL21
         nxt_fwd_up   = 1'b0;
      end
      else if (!req_upstream_i)
      begin
         if (req_is_io_i)
         begin
            // Filter touches only the I/O decodes, here and upstream
            nxt_fwd_down = io_space_en_i && !io_up_addr &&
                           (disp_any || (io_win_hit && !isa_alias)); // see RL7 RL8 RL10
            nxt_out_addr = {{(64-IO_AW){1'b0}}, req_addr_i[IO_AW-1:0] & io_mask};
         end
         else
         begin
            nxt_fwd_down = mem_space_en_i && (disp_any || np_pri_hit || pf_pri_hit); // see RL1 RL11
            if (remap_enable_i && np_pri_hit)
            begin
               nxt_out_addr = req_addr_i - np_base_offset; // see RL11 RL12
            end
            else if (remap_enable_i && pf_pri_hit)
            begin
               nxt_out_addr = req_addr_i - pf_base_offset; // see RL13
            end
         end
      end
      else
      begin
         if (req_is_io_i)
         begin
            nxt_fwd_up = bus_master_en_i && !disp_any &&
                         (!io_win_hit || isa_alias || !io_space_en_i); // see RL9
         end
         else
         begin
            nxt_fwd_up = bus_master_en_i && !disp_any &&
                         (!(np_sec_hit || pf_sec_hit) || !mem_space_en_i); // see RL1 RL14
            if (upw_hit)
            begin
               nxt_out_addr = req_addr_i + upstream_window_offset; // see RL15 RL18
            end
            else
            begin
               nxt_out_addr = req_addr_i; // see RL17
            end
         end
      end
   end

   // ************************************************************
   // Registered answer, one cycle after the request
   // ************************************************************
   always @(posedge clk_i)
   begin
      if (srst_i)
      begin
         resp_valid_o             <= 1'b0;
         claim_o                  <= 1'b0;
         fwd_down_o               <= 1'b0;
         fwd_up_o                 <= 1'b0;
         out_addr_o               <= `BAD_ADDR_RST;
         palette_snoop_o          <= 1'b0;
         upstream_primary_limit_o <= `BAD_ADDR_RST;
      end
      else
      begin
         resp_valid_o             <= req_valid_i;
         claim_o                  <= req_valid_i && (nxt_fwd_down || nxt_fwd_up);
         fwd_down_o               <= req_valid_i && nxt_fwd_down;
         fwd_up_o                 <= req_valid_i && nxt_fwd_up;
         palette_snoop_o          <= 1'b0 & palette_snoop_wr_i; // see RL6
         upstream_primary_limit_o <= nxt_upstream_primary_limit; // see RL16
         if (req_valid_i)
         begin
            out_addr_o <= nxt_out_addr;
         end
      end
   end

endmodule // bad_decode_remap
`default_nettype wire

//--- core/bad_defs.vh
// Constants for the bridge address decode and remap block.
// Assumes inclusion by bare name from core files only.
`ifndef BAD_DEFS_VH
`define BAD_DEFS_VH

// ***************************************************************
// Legacy display windows
// ***************************************************************
`define BAD_DISP_MEM_LO     64'h0000_0000_000a_0000
`define BAD_DISP_MEM_HI     64'h0000_0000_000b_ffff
`define BAD_DISP_IO_A_LO    10'h3b0
`define BAD_DISP_IO_A_HI    10'h3bb
`define BAD_DISP_IO_B_LO    10'h3c0
`define BAD_DISP_IO_B_HI    10'h3df

// ***************************************************************
// Expansion-bus alias filter and window granularity
// ***************************************************************
`define BAD_ISA_OFS_MSB     9
`define BAD_ISA_OFS_LSB     8
`define BAD_IO_GRAN_LSB     12
`define BAD_MEM_GRAN_LSB    20
`define BAD_UPPER_ZERO_HI   16

// ***************************************************************
// Upstream translation window register offsets
// ***************************************************************
`define BAD_UPW_OFS_FIRST   8'h68
`define BAD_UPW_OFS_LAST    8'h7c

// ***************************************************************
// Reset values
// ***************************************************************
`define BAD_ADDR_RST        64'h0000_0000_0000_0000

`endif

//--- core/bad_io_decode.v
// I/O decode: display register aliases, I/O window, expansion-bus filter.
// Assumes all inputs are stable in the cycle they are sampled.
`timescale 1ns/1ps
`default_nettype none
`include "bad_defs.vh"

module bad_io_decode
(
   input  wire [31:0] io_addr_i,
   input  wire [31:0] io_base_i,
   input  wire [31:0] io_limit_i,
   input  wire        isa_filter_i,
   input  wire        display_full_io_decode_i,
   output wire        disp_hit_o,
   output wire        win_hit_o,
   output wire        isa_alias_o
);

   wire [9:0] low10;
   wire       upper_zero;
   wire       alias10;
   wire       win_en;

   assign low10      = io_addr_i[9:0];
   assign upper_zero = (io_addr_i[31:10] == 22'h000000);
   assign alias10    = ((low10 >= `BAD_DISP_IO_A_LO) && (low10 <= `BAD_DISP_IO_A_HI)) ||
                       ((low10 >= `BAD_DISP_IO_B_LO) && (low10 <= `BAD_DISP_IO_B_HI));
   // Ten-bit mode ignores bits 31:10, full mode needs them zero
   assign disp_hit_o = alias10 && (!display_full_io_decode_i || upper_zero); // see RL3 RL4 RL5

   // Window on 4-KB granules, disabled when base above limit
   assign win_en    = (io_base_i[31:`BAD_IO_GRAN_LSB] <= io_limit_i[31:`BAD_IO_GRAN_LSB]);
   assign win_hit_o = win_en &&
                      (io_addr_i[31:`BAD_IO_GRAN_LSB] >= io_base_i[31:`BAD_IO_GRAN_LSB]) &&
                      (io_addr_i[31:`BAD_IO_GRAN_LSB] <= io_limit_i[31:`BAD_IO_GRAN_LSB]); // see RL22

   // Upper 768 bytes of each 1-KB block below 64 KB
   assign isa_alias_o = isa_filter_i &&
                        (io_addr_i[31:`BAD_UPPER_ZERO_HI] == 16'h0000) &&
                        (io_addr_i[`BAD_ISA_OFS_MSB:`BAD_ISA_OFS_LSB] != 2'b00); // see RL7 RL9

endmodule // bad_io_decode
`default_nettype wire

//--- core/bad_mem_window.v
// One memory window: hit test on 2^GRAN_LSB-byte granules (1 MB by default) with base-above-limit disable.
// Assumes 64-bit addresses, comparison only, no state.
`timescale 1ns/1ps
`default_nettype none
`include "bad_defs.vh"

module bad_mem_window
#(
   parameter GRAN_LSB = `BAD_MEM_GRAN_LSB
)
(
   input  wire [63:0] addr_i,
   input  wire [63:0] base_i,
   input  wire [63:0] limit_i,
   output wire        hit_o
);

   wire en;

   assign en    = (base_i[63:GRAN_LSB] <= limit_i[63:GRAN_LSB]); // see RL23
   assign hit_o = en && (addr_i[63:GRAN_LSB] >= base_i[63:GRAN_LSB]) &&
                  (addr_i[63:GRAN_LSB] <= limit_i[63:GRAN_LSB]); // see RL23

endmodule // bad_mem_window
`default_nettype wire

//--- dv/bad_decode_remap_bench.sv
// Self-checking bench for the decode and remap block.
// Assumes the design and checker files are compiled first.
`timescale 1ns/1ps
`default_nettype none
module bad_decode_remap_bench;
   logic clk_i = 1'b0, srst_i = 1'b1, req_valid_i, req_upstream_i, req_is_io_i;
   logic mem_space_en_i, bus_master_en_i, io_space_en_i, display_enable_i, palette_snoop_wr_i;
   logic display_full_io_decode_i, isa_filter_i, remap_enable_i, opaque_memory_enable_i;
   logic [63:0] req_addr_i, opaque_base_i, opaque_limit_i, primary_np_base_i, primary_np_limit_i;
   logic [63:0] secondary_np_remap_base_i, primary_pf_base_i, primary_pf_limit_i;
   logic [63:0] secondary_pf_remap_base_i, upstream_primary_base_i, upstream_secondary_base_i;
   logic [63:0] upstream_secondary_limit_i, out_addr_o, upstream_primary_limit_o, far_addr;
   logic [31:0] io_base_i, io_limit_i;
   logic [4:0]  io_remap_count_i;
   logic        resp_valid_o, claim_o, fwd_down_o, fwd_up_o, palette_snoop_o;
   int          miscompares = 0, num_checks = 0;
   localparam logic [1:0] DN = 2'b10, UP = 2'b01, NO = 2'b00;
   // ***************************************************************
   // Design, far side and tasks
   // ***************************************************************
   bad_decode_remap u_bad_decode_remap (.*);
   bad_far_model u_bad_far_model (.clk_i(clk_i), .fwd_down_i(fwd_down_o), .fwd_up_i(fwd_up_o),
                                  .addr_i(out_addr_o), .last_addr_o(far_addr));
   always #4 clk_i = ~clk_i;
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("ERROR %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   task automatic req(input logic up, input logic io, input logic [63:0] a,
                      input logic [1:0] dir, input logic [63:0] ea);
      req_upstream_i = up;
      req_is_io_i = io;
      req_addr_i = a;
      req_valid_i = 1'b1;
      @(negedge clk_i);
      req_valid_i = 1'b0;
      chk({resp_valid_o, claim_o}, {1'b1, |dir});
      chk({fwd_down_o, fwd_up_o}, dir);
      if (|dir)
         chk(out_addr_o, ea);
      @(negedge clk_i);
      chk({resp_valid_o, claim_o, fwd_down_o, fwd_up_o}, 4'h0);
      if (|dir)
         chk(far_addr, ea);
   endtask
   task automatic wrap_up;
      $display("checks %0d, mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial
   begin
      #(8 * 600);
      miscompares++;
      $display("ERROR %0t: watchdog expired", $time);
      wrap_up();
   end
   initial
   begin
      {req_valid_i, req_upstream_i, req_is_io_i, display_enable_i, isa_filter_i} = '0;
      {display_full_io_decode_i, remap_enable_i, opaque_memory_enable_i} = '0;
      {mem_space_en_i, bus_master_en_i, io_space_en_i, palette_snoop_wr_i} = '1;
      req_addr_i = 64'h0;
      io_remap_count_i = 5'h0;
      io_base_i = 32'h0000_1000;
      io_limit_i = 32'h0000_1fff;
      primary_np_base_i = 64'h0000_0000_8000_0000;
      primary_np_limit_i = 64'h0000_0000_80ff_ffff;
      secondary_np_remap_base_i = 64'h0000_0000_4000_0000;
      primary_pf_base_i = 64'h0000_0001_0000_0000;
      primary_pf_limit_i = 64'h0000_0001_00ff_ffff;
      secondary_pf_remap_base_i = 64'h0000_0000_c000_0000;
      upstream_primary_base_i = 64'h0000_0002_0000_0000;
      upstream_secondary_base_i = 64'h0000_0000_2000_0000;
      upstream_secondary_limit_i = 64'h0000_0000_200f_ffff;
      opaque_base_i = 64'h0000_0000_8010_0000;
      opaque_limit_i = 64'h0000_0000_8010_ffff;
      repeat (2) @(negedge clk_i);
      srst_i = 1'b0;
      display_enable_i = 1'b1;
      req(0, 0, 64'ha0000, DN, 64'ha0000);
      req(0, 0, 64'hbffff, DN, 64'hbffff);
      req(0, 0, 64'hc0000, NO, 64'h0);
      req(0, 1, 64'h7b0, DN, 64'h7b0);
      req(1, 0, 64'ha0000, NO, 64'h0);
      display_full_io_decode_i = 1'b1;
      req(0, 1, 64'h7b0, NO, 64'h0);
      req(0, 1, 64'h3df, DN, 64'h3df);
      display_enable_i = 1'b0;
      req(0, 1, 64'h3df, NO, 64'h0);
      req(1, 0, 64'ha0000, UP, 64'ha0000);
      chk(palette_snoop_o, 64'h0);
      $display("display test done");
      req(0, 1, 64'h1100, DN, 64'h1100);
      isa_filter_i = 1'b1;
      req(0, 1, 64'h13ff, NO, 64'h0);
      req(0, 1, 64'h1000, DN, 64'h1000);
      req(1, 1, 64'h1100, UP, 64'h1100);
      req(1, 1, 64'h10ff, NO, 64'h0);
      req(0, 0, 64'h8000_0040, DN, 64'h8000_0040);
      isa_filter_i = 1'b0;
      $display("alias filter test done");
      remap_enable_i = 1'b1;
      req(0, 0, 64'h8000_1234, DN, 64'h4000_1234);
      req(0, 0, 64'h1_0000_0010, DN, 64'hc000_0010);
      req(1, 0, 64'h4000_0000, NO, 64'h0);
      req(1, 0, 64'h40ff_ffff, NO, 64'h0);
      req(1, 0, 64'hc0ff_ffff, NO, 64'h0);
      req(1, 0, 64'h4100_0000, UP, 64'h4100_0000);
      req(1, 0, 64'h8000_0000, UP, 64'h8000_0000);
      $display("remap test done");
      req(1, 0, 64'h2000_0100, UP, 64'h2_0000_0100);
      req(1, 0, 64'h200f_ffff, UP, 64'h2_000f_ffff);
      req(1, 0, 64'h2010_0000, UP, 64'h2010_0000);
      chk(upstream_primary_limit_o, 64'h2_000f_ffff);
      $display("upstream window test done");
      opaque_memory_enable_i = 1'b1;
      req(0, 0, 64'h8010_0000, NO, 64'h0);
      req(1, 0, 64'h8010_ffff, NO, 64'h0);
      opaque_memory_enable_i = 1'b0;
      req(0, 0, 64'h8010_0000, DN, 64'h4010_0000);
      $display("opaque test done");
      io_base_i = 32'h0001_0000;
      io_limit_i = 32'h0001_0fff;
      req(0, 1, 64'h1_0010, DN, 64'h1_0010);
      io_remap_count_i = 5'd16;
      req(0, 1, 64'h1_0010, DN, 64'h10);
      $display("io remap test done");
      primary_np_limit_i = 64'h0000_0000_7fff_ffff;
      req(0, 0, 64'h8000_0000, NO, 64'h0);
      req(1, 0, 64'h4000_0000, UP, 64'h4000_0000);
      primary_np_limit_i = 64'h0000_0000_80ff_ffff;
      {mem_space_en_i, io_space_en_i} = 2'b00;
      req(0, 0, 64'h8000_1234, NO, 64'h0);
      req(1, 0, 64'h4000_0000, UP, 64'h4000_0000);
      req(0, 1, 64'h1_0010, NO, 64'h0);
      req(1, 1, 64'h1_0010, UP, 64'h1_0010);
      bus_master_en_i = 1'b0;
      req(1, 0, 64'h4100_0000, NO, 64'h0);
      $display("window and enable test done");
      wrap_up();
   end
endmodule // bad_decode_remap_bench
`default_nettype wire

//--- dv/bad_decode_remap_sva.sv
// Checker for the decode and remap block, watching its ports only.
// Assumes bind onto bad_decode_remap, one clock, synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module bad_decode_remap_sva
(
   input wire logic        clk_i,
   input wire logic        srst_i,
   input wire logic        req_valid_i,
   input wire logic        req_upstream_i,
   input wire logic        req_is_io_i,
   input wire logic [63:0] req_addr_i,
   input wire logic        mem_space_en_i,
   input wire logic        display_enable_i,
   input wire logic        isa_filter_i,
   input wire logic        opaque_memory_enable_i,
   input wire logic [63:0] opaque_base_i,
   input wire logic [63:0] opaque_limit_i,
   input wire logic [63:0] upstream_primary_base_i,
   input wire logic [63:0] upstream_secondary_base_i,
   input wire logic [63:0] upstream_secondary_limit_i,
   input wire logic        resp_valid_o,
   input wire logic        claim_o,
   input wire logic        fwd_down_o,
   input wire logic        fwd_up_o,
   input wire logic [63:0] out_addr_o,
   input wire logic        palette_snoop_o,
   input wire logic [63:0] upstream_primary_limit_o
);
   // ***************************************************************
   // Decode properties
   // ***************************************************************
   wire opq_hit  = opaque_memory_enable_i && !req_is_io_i && req_addr_i >= opaque_base_i
                   && req_addr_i <= opaque_limit_i;
   wire disp_mem = display_enable_i && !req_is_io_i && req_addr_i >= 64'h0000_0000_000a_0000
                   && req_addr_i <= 64'h0000_0000_000b_ffff;
   wire isa_down = req_valid_i && !req_upstream_i && req_is_io_i && isa_filter_i
                   && !display_enable_i && req_addr_i[63:16] == 48'h0 && req_addr_i[9:8] != 2'h0;
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (srst_i);
   sequence s_answer;
      resp_valid_o ##0 (claim_o == (fwd_down_o || fwd_up_o));
   endsequence
   sequence s_disp_down;
      req_valid_i && !req_upstream_i && disp_mem && mem_space_en_i && !opq_hit;
   endsequence
   resp_follows_a: assert property (req_valid_i |=> s_answer)
      else $error("answer missing or claim inconsistent");
   resp_only_a: assert property (!req_valid_i |=> !resp_valid_o)
      else $error("answer without request");
   one_way_a: assert property (!(fwd_down_o && fwd_up_o))
      else $error("forwarded both ways");
   palette_zero_a: assert property (!palette_snoop_o)
      else $error("palette snoop bit not zero");
   disp_down_a: assert property (s_disp_down |=> fwd_down_o)
      else $error("frame buffer access not forwarded down");
   disp_up_a: assert property (req_valid_i && req_upstream_i && disp_mem |=> !fwd_up_o)
      else $error("frame buffer access forwarded up");
   opaque_block_a: assert property (req_valid_i && opq_hit |=> !claim_o)
      else $error("opaque range claimed");
   isa_block_a: assert property (isa_down |=> !fwd_down_o)
      else $error("alias forwarded down");
   addr_hold_a: assert property (!req_valid_i |=> $stable(out_addr_o))
      else $error("address changed without request");
   up_limit_a: assert property (1'b1 |=> upstream_primary_limit_o ==
      $past(upstream_secondary_limit_i + upstream_primary_base_i - upstream_secondary_base_i))
      else $error("upstream primary limit wrong");
endmodule // bad_decode_remap_sva
bind bad_decode_remap bad_decode_remap_sva u_sva (.*);
`default_nettype wire

//--- dv/bad_far_model.sv
// Far-side agent: records each forwarded cycle as the other bus sees it.
// Assumes forward pulses last one cycle with the address valid alongside.
`timescale 1ns/1ps
`default_nettype none
module bad_far_model
(
   input  wire logic        clk_i,
   input  wire logic        fwd_down_i,
   input  wire logic        fwd_up_i,
   input  wire logic [63:0] addr_i,
   output var  logic [63:0] last_addr_o
);
   // ***************************************************************
   // Capture of forwarded cycles
   // ***************************************************************
   initial last_addr_o = 64'h0;
   always @(posedge clk_i)
      if (fwd_down_i || fwd_up_i)
         last_addr_o <= addr_i;
endmodule // bad_far_model
`default_nettype wire
